/* File: hpp_regs.svh */
// hpp_regs.svh: encodings, reset values and timing counts of the
// parallel high-voltage programming port.
// assumes the includer already uses `timescale and nettype settings.
`ifndef HPP_REGS_SVH
`define HPP_REGS_SVH

// action select codes seen on the load strobe rising edge
`define HPP_ACT_ADDR     2'h0
`define HPP_ACT_DATA     2'h1
`define HPP_ACT_CMD      2'h2
`define HPP_ACT_IDLE     2'h3

// command byte codes
`define HPP_CMD_NOP      8'h00
`define HPP_CMD_ERASE    8'h80
`define HPP_CMD_WR_FUSE  8'h40
`define HPP_CMD_WR_LOCK  8'h20
`define HPP_CMD_WR_FLASH 8'h10
`define HPP_CMD_WR_EE    8'h11
`define HPP_CMD_RD_SIG   8'h08
`define HPP_CMD_RD_FUSE  8'h04
`define HPP_CMD_RD_FLASH 8'h02
`define HPP_CMD_RD_EE    8'h03

// fuse/lock read selection, {second, first} byte select
`define HPP_SEL_FUSE_LO  2'h0
`define HPP_SEL_LOCK     2'h1
`define HPP_SEL_FUSE_EXT 2'h2
`define HPP_SEL_FUSE_HI  2'h3

// reset values
`define HPP_BYTE_RST     8'h00
`define HPP_ENTRY_PAT    4'h0

// entry pattern hold time and its cycle count at the 5 ns clock
`define HPP_CLK_PERIOD_NS 5
`define HPP_ENTRY_HOLD_NS 10000
`define HPP_ENTRY_HOLD_CYC \
  ((`HPP_ENTRY_HOLD_NS + `HPP_CLK_PERIOD_NS - 1) / `HPP_CLK_PERIOD_NS)

`endif

/* File: hpp_pkg.sv */
// hpp_pkg.sv: types shared by the programming port modules.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package hpp_pkg;
  // operation requested from the nonvolatile array
  typedef enum logic [2:0] {
    HPP_OP_NONE, HPP_OP_ERASE_FLASH, HPP_OP_ERASE_EE, HPP_OP_ERASE_LOCK,
    HPP_OP_PROG_FLASH, HPP_OP_PROG_EE, HPP_OP_WR_FUSE, HPP_OP_WR_LOCK
  } hpp_op_t;
  // self-timed sequencer states
  typedef enum logic [2:0] {
    HPP_ST_IDLE, HPP_ST_ER_FLASH, HPP_ST_ER_EE, HPP_ST_ER_LOCK, HPP_ST_OP
  } hpp_st_t;
endpackage
`default_nettype wire

/* File: hpp_edge.sv */
// hpp_edge.sv: rising and falling edge detector for strobe pins.
// assumes the strobe is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module hpp_edge #(
  parameter logic IDLE_LVL = 1'b0   // level the pin rests at
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // strobe in, edges out
  input  wire logic sig,
  output logic      rise,
  output logic      fall
);
  logic prev_q;  // strobe one cycle ago

  // previous level; reset to rest level so no false edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      prev_q <= IDLE_LVL;
    else
      prev_q <= sig;
  end

  assign rise = sig & ~prev_q;
  assign fall = ~sig & prev_q;
endmodule
`default_nettype wire

/* File: hpp_page_buf.sv */
// hpp_page_buf.sv: page buffer holding one page of words.
// assumes writes and reads come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module hpp_page_buf #(
  parameter int WORDS = 64,         // words per page
  parameter int WIDTH = 16,         // bits per word
  parameter int IW    = $clog2(WORDS)
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // write side
  input  wire logic             wr_en,
  input  wire logic [IW-1:0]    wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  // registered read side
  input  wire logic [IW-1:0]    rd_idx,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [WORDS];  // page storage, no reset needed

  // storage write
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_data;
  end

  // read port, one cycle latency
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rd_data <= '0;
    else
      rd_data <= mem[rd_idx];
  end
endmodule
`default_nettype wire

/* File: hpp_prog_port.sv */
// hpp_prog_port.sv: parallel high-voltage programming port, top level.
// assumes pins are synchronous to clk and that the array below answers
// each nvm_start_q with one nvm_done pulse when its self-timed job ends.
`timescale 1ns/1ps
`default_nettype none
`include "hpp_regs.svh"
module hpp_prog_port #(
  parameter int PAGE_WORDS = 64,               // flash words per page
  parameter int PW_BITS    = $clog2(PAGE_WORDS),
  parameter int PG_W       = 16 - PW_BITS      // page number width
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // mode entry: reset pin at high voltage
  input  wire logic                hv_entry,
  output logic                     prog_mode_q,
  // strobes and selects
  input  wire logic                load_strobe,
  input  wire logic                page_latch_strobe,
  input  wire logic                wr_n,
  input  wire logic                oe_n,
  input  wire logic                action_select_lo,
  input  wire logic                action_select_hi,
  input  wire logic                byte_select_first,
  input  wire logic                byte_select_second,
  // bidirectional data bus
  input  wire logic [7:0]          data_in,
  output logic      [7:0]          data_out_q,
  output logic                     data_oe_q,
  output logic                     ready_busy_out,
  // fuse and lock state of the part
  input  wire logic                preserve_eeprom_fuse,
  input  wire logic [7:0]          fuse_lo,
  input  wire logic [7:0]          fuse_hi,
  input  wire logic [7:0]          fuse_ext,
  input  wire logic [7:0]          lock_bits,
  // nonvolatile array side
  output logic                     nvm_start_q,
  output hpp_pkg::hpp_op_t         nvm_op_q,
  output logic      [PG_W-1:0]     nvm_page_q,
  output logic      [15:0]         nvm_addr_q,
  output logic      [1:0]          nvm_sel_q,
  output logic      [7:0]          nvm_wdata_q,
  output logic                     nvm_buf_valid_q,
  input  wire logic                nvm_done,
  input  wire logic [15:0]         nvm_rd_data,
  input  wire logic [PW_BITS-1:0]  pb_rd_idx,
  output logic      [15:0]         pb_rd_data
);
  import hpp_pkg::*;

  // refuse page sizes and page widths the addressing cannot serve
  if (PAGE_WORDS < 2 || PAGE_WORDS > 256 ||
      (1 << PW_BITS) != PAGE_WORDS || PG_W != 16 - PW_BITS)
  begin : g_bad_page
    $error("page size must be a power of two from 2 to 256");
  end

  ////////////////////////////////////////////////////////////////////////
  // strobe edges
  logic ld_rise;     // load strobe rising
  logic pl_rise;     // page latch rising
  logic wr_fall;     // write strobe falling
  logic unused_e;    // edges nobody needs
  logic unused_f;
  logic unused_g;

  hpp_edge #(.IDLE_LVL(1'b0)) u_ld (.clk(clk), .rstn(rstn),
    .sig(load_strobe), .rise(ld_rise), .fall(unused_e));
  hpp_edge #(.IDLE_LVL(1'b0)) u_pl (.clk(clk), .rstn(rstn),
    .sig(page_latch_strobe), .rise(pl_rise), .fall(unused_f));
  hpp_edge #(.IDLE_LVL(1'b1)) u_wr (.clk(clk), .rstn(rstn),
    .sig(wr_n), .rise(unused_g), .fall(wr_fall));

  ////////////////////////////////////////////////////////////////////////
  // programming mode entry and exit
  localparam int HOLD = `HPP_ENTRY_HOLD_CYC;
  logic [11:0] hold_cnt_q;   // cycles the entry pattern has stood
  logic        entry_bad_q;  // pattern moved too early; wait for exit
  logic [3:0]  entry_pat;    // page latch, actions, first byte select

  assign entry_pat = {page_latch_strobe, action_select_hi,
                      action_select_lo, byte_select_first};

  // the pattern must stand still the whole hold time, else no entry
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prog_mode_q <= 1'b0;
      hold_cnt_q  <= '0;
      entry_bad_q <= 1'b0;
    end
    else if (!hv_entry)
    begin
      prog_mode_q <= 1'b0;
      hold_cnt_q  <= '0;
      entry_bad_q <= 1'b0;
    end
    else if (!prog_mode_q && !entry_bad_q)
    begin
      if (entry_pat != `HPP_ENTRY_PAT)
        entry_bad_q <= 1'b1;
      else if (hold_cnt_q == 12'(HOLD - 1))
        prog_mode_q <= 1'b1;
      else
        hold_cnt_q <= hold_cnt_q + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command, address and data loading
  logic [7:0] cmd_q;      // loaded command byte
  logic [7:0] addr_lo_q;  // address low byte
  logic [7:0] addr_hi_q;  // address high byte
  logic [7:0] dat_lo_q;   // data low byte
  logic [7:0] dat_hi_q;   // data high byte
  logic       ld_ok;      // load strobe accepted
  logic [1:0] act;        // action select pair

  assign act   = {action_select_hi, action_select_lo};
  assign ld_ok = ld_rise && prog_mode_q;

  // registers keep their value between operations
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_q     <= `HPP_CMD_NOP;
      addr_lo_q <= `HPP_BYTE_RST;
      addr_hi_q <= `HPP_BYTE_RST;
      dat_lo_q  <= `HPP_BYTE_RST;
      dat_hi_q  <= `HPP_BYTE_RST;
    end
    else if (ld_ok)
    begin
      unique case (act)
        `HPP_ACT_ADDR:
          if (byte_select_first)
            addr_hi_q <= data_in;
          else
            addr_lo_q <= data_in;
        `HPP_ACT_DATA:
          if (byte_select_first)
            dat_hi_q <= data_in;
          else
            dat_lo_q <= data_in;
        `HPP_ACT_CMD:
          cmd_q <= data_in;
        `HPP_ACT_IDLE:
          ;  // no action
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // page buffer and write control
  logic pb_wr;  // latch a word into the page buffer
  logic nop_ld; // no-operation command being loaded
  logic prog_end;  // page program finished

  assign pb_wr  = pl_rise && prog_mode_q;
  assign nop_ld = ld_ok && act == `HPP_ACT_CMD && data_in == `HPP_CMD_NOP;

  hpp_page_buf #(.WORDS(PAGE_WORDS), .WIDTH(16)) u_pb (
    .clk(clk), .rstn(rstn),
    .wr_en(pb_wr),
    .wr_idx(addr_lo_q[PW_BITS-1:0]),
    .wr_data({dat_hi_q, dat_lo_q}),
    .rd_idx(pb_rd_idx), .rd_data(pb_rd_data));

  // buffer holds fresh data; a latch in the clearing cycle wins
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      nvm_buf_valid_q <= 1'b0;
    else if (pb_wr)
      nvm_buf_valid_q <= 1'b1;
    else if (nop_ld || prog_end)
      nvm_buf_valid_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // self-timed operation sequencer
  hpp_st_t st_q;   // current state
  hpp_st_t st_d;   // next state
  hpp_op_t op_d;   // operation to start
  logic    go;     // write pulse accepted

  assign go = wr_fall && prog_mode_q && st_q == HPP_ST_IDLE;
  assign prog_end = nvm_done && st_q == HPP_ST_OP &&
                    (nvm_op_q == HPP_OP_PROG_FLASH ||
                     nvm_op_q == HPP_OP_PROG_EE);

  // next state and the operation started on entering it
  always_comb
  begin
    st_d = st_q;
    op_d = HPP_OP_NONE;
    unique case (st_q)
      HPP_ST_IDLE:
        if (go)
        begin
          st_d = HPP_ST_OP;
          case (cmd_q)
            `HPP_CMD_ERASE:
            begin
              st_d = HPP_ST_ER_FLASH;
              op_d = HPP_OP_ERASE_FLASH;
            end
            `HPP_CMD_WR_FLASH: op_d = HPP_OP_PROG_FLASH;
            `HPP_CMD_WR_EE:    op_d = HPP_OP_PROG_EE;
            `HPP_CMD_WR_FUSE:  op_d = HPP_OP_WR_FUSE;
            `HPP_CMD_WR_LOCK:  op_d = HPP_OP_WR_LOCK;
            default:           st_d = HPP_ST_IDLE;  // reads, nop
          endcase
        end
      HPP_ST_ER_FLASH:
        if (nvm_done)
        begin
          // a programmed fuse reads 0 and keeps the eeprom
          if (preserve_eeprom_fuse)
          begin
            st_d = HPP_ST_ER_EE;
            op_d = HPP_OP_ERASE_EE;
          end
          else
          begin
            st_d = HPP_ST_ER_LOCK;
            op_d = HPP_OP_ERASE_LOCK;
          end
        end
      HPP_ST_ER_EE:
        if (nvm_done)
        begin
          st_d = HPP_ST_ER_LOCK;
          op_d = HPP_OP_ERASE_LOCK;
        end
      HPP_ST_ER_LOCK, HPP_ST_OP:
        if (nvm_done)
          st_d = HPP_ST_IDLE;
    endcase
  end

  // state, start pulse, ready/busy; busy until the array reports done
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q           <= HPP_ST_IDLE;
      nvm_start_q    <= 1'b0;
      nvm_op_q       <= HPP_OP_NONE;
      ready_busy_out <= 1'b1;
    end
    else
    begin
      st_q           <= st_d;
      nvm_start_q    <= op_d != HPP_OP_NONE;
      ready_busy_out <= st_d == HPP_ST_IDLE;
      if (op_d != HPP_OP_NONE)
        nvm_op_q <= op_d;
    end
  end

  // operands frozen when an operation is started
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      nvm_page_q  <= '0;
      nvm_addr_q  <= '0;
      nvm_sel_q   <= '0;
      nvm_wdata_q <= `HPP_BYTE_RST;
    end
    else if (go)
    begin
      nvm_page_q  <= PG_W'({addr_hi_q, addr_lo_q} >> PW_BITS);
      nvm_addr_q  <= {addr_hi_q, addr_lo_q};
      nvm_sel_q   <= {byte_select_second, byte_select_first};
      nvm_wdata_q <= dat_lo_q;
    end
    else if (st_q == HPP_ST_IDLE)
      nvm_addr_q  <= {addr_hi_q, addr_lo_q};  // read address follows
  end

  ////////////////////////////////////////////////////////////////////////
  // read back onto the data bus
  // byte picked for a read command and the byte selects
  function automatic logic [7:0] rd_byte(input logic [7:0] cmd,
                                         input logic [1:0] sel,
                                         input logic [15:0] word);
    logic [7:0] b;
    b = 8'h00;
    case (cmd)
      `HPP_CMD_RD_FLASH, `HPP_CMD_RD_SIG:
        b = sel[0] ? word[15:8] : word[7:0];
      `HPP_CMD_RD_EE:
        b = word[7:0];
      `HPP_CMD_RD_FUSE:
        case (sel)
          `HPP_SEL_FUSE_LO:  b = fuse_lo;
          `HPP_SEL_LOCK:     b = lock_bits;
          `HPP_SEL_FUSE_EXT: b = fuse_ext;
          `HPP_SEL_FUSE_HI:  b = fuse_hi;
        endcase
      default:
        b = 8'h00;
    endcase
    return b;
  endfunction

  // one cycle after output enable falls the bus turns round
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_oe_q  <= 1'b0;
      data_out_q <= `HPP_BYTE_RST;
    end
    else
    begin
      data_oe_q  <= !oe_n && prog_mode_q;
      data_out_q <= rd_byte(cmd_q, {byte_select_second, byte_select_first},
                            nvm_rd_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence erase_wr_s;
    go && cmd_q == `HPP_CMD_ERASE;
  endsequence
  sequence erase_start_s;
    nvm_start_q && nvm_op_q == HPP_OP_ERASE_FLASH && !ready_busy_out;
  endsequence

  entry_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(prog_mode_q) |-> $past(hv_entry) && hold_cnt_q == 12'(HOLD - 1))
    else $error("mode entered without full hold");
  mode_exit_a: assert property (@(posedge clk) disable iff (!rstn)
    !hv_entry |=> !prog_mode_q)
    else $error("mode kept after high voltage removed");
  erase_start_a: assert property (@(posedge clk) disable iff (!rstn)
    erase_wr_s |=> erase_start_s)
    else $error("erase not started by write pulse");
  busy_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    st_q != HPP_ST_IDLE && !nvm_done |=> !ready_busy_out)
    else $error("ready shown during operation");
  lock_last_a: assert property (@(posedge clk) disable iff (!rstn)
    nvm_start_q && nvm_op_q == HPP_OP_ERASE_LOCK |->
      $past(st_q) inside {HPP_ST_ER_FLASH, HPP_ST_ER_EE})
    else $error("locks erased before memory");
  cmd_load_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_ok && act == `HPP_ACT_CMD |=> cmd_q == $past(data_in))
    else $error("command byte not loaded");
  addr_sel_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_ok && act == `HPP_ACT_ADDR && !byte_select_first |=>
      addr_lo_q == $past(data_in) && $stable(addr_hi_q))
    else $error("wrong address byte loaded");
  ignore_a: assert property (@(posedge clk) disable iff (!rstn)
    !prog_mode_q |=> $stable(cmd_q) && !nvm_start_q)
    else $error("strobe acted on outside programming mode");
  bus_drive_a: assert property (@(posedge clk) disable iff (!rstn)
    data_oe_q |-> $past(!oe_n))
    else $error("bus driven without output enable");
  nop_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    nop_ld && !pb_wr |=> !nvm_buf_valid_q)
    else $error("no-operation left write state set");
endmodule
`default_nettype wire

/* File: hpp_prog_model.sv */
// hpp_prog_model.sv: behavioural external programmer driving the pins.
// assumes the bench owns clk and calls one task at a time, each task
// entered and left just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module hpp_prog_model #(
  parameter int PW_CYC  = 50,  // 250 ns minimum strobe width
  parameter int SET_CYC = 60000  // 300 us settle after entry
) (
  // clock
  input  wire logic       clk,
  // pins toward the device
  output logic            hv_entry,
  output logic            load_strobe,
  output logic            page_latch_strobe,
  output logic            wr_n,
  output logic            oe_n,
  output logic [1:0]      act,
  output logic            byte_select_first,
  output logic            byte_select_second,
  output logic [7:0]      prog_data,
  // status from the device
  input  wire logic       ready_busy_out
);
  ////////////////////////////////////////////////////////////////////////
  // idle levels; entry pattern already all zero
  initial
  begin
    hv_entry = 1'b0;
    load_strobe = 1'b0;
    page_latch_strobe = 1'b0;
    wr_n = 1'b1;
    oe_n = 1'b1;
    act = 2'h0;
    byte_select_first = 1'b0;
    byte_select_second = 1'b0;
    prog_data = 8'h00;
  end
  // one strobe width; shorter pulses are not legal for a programmer
  task automatic pw();
    repeat (PW_CYC) @(posedge clk);
    #1;
  endtask
  // load an address, data or command byte
  task automatic load(input logic [1:0] a, input logic b1,
                      input logic [7:0] d);
    act = a;
    byte_select_first = b1;
    prog_data = d;
    load_strobe = 1'b1;
    pw();
    load_strobe = 1'b0;
    pw();
  endtask
  // positive page latch pulse
  task automatic latch();
    page_latch_strobe = 1'b1;
    pw();
    page_latch_strobe = 1'b0;
    pw();
  endtask
  // negative write pulse; caller waits for ready itself
  task automatic wr_pulse();
    wr_n = 1'b0;
    pw();
    wr_n = 1'b1;
  endtask
  // bounded wait for ready before any further command
  task automatic wait_ready(output logic ok);
    int n;
    n = 0;
    while (ready_busy_out !== 1'b1 && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    ok = ready_busy_out;
  endtask
  // output enable and byte selects, then two edges for the answer
  task automatic pins(input logic o, input logic b2, input logic b1);
    oe_n = o;
    byte_select_second = b2;
    byte_select_first = b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // high-voltage entry; b1 high spoils the pattern on purpose
  task automatic enter(input logic b1);
    hv_entry = 1'b0;
    act = 2'h0;
    byte_select_first = b1;
    @(posedge clk);
    #1;
    hv_entry = 1'b1;
    repeat (2100) @(posedge clk);
    #1;
    byte_select_first = 1'b0;
    // a spoiled entry gives no mode, so no settling is owed
    if (!b1)
      repeat (SET_CYC) @(posedge clk);
    #1;
  endtask
  // reset pin back to ground level
  task automatic leave();
    hv_entry = 1'b0;
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// tb_top.sv: self-checking bench for the programming port.
// assumes hpp_pkg, the header and the programmer model come first.
`timescale 1ns/1ps
`default_nettype none
`include "hpp_regs.svh"
module tb_top;
  import hpp_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // row: command byte, array jobs it starts, first job
  typedef struct {
    logic [7:0] cmd;
    int         n_ops;
    hpp_op_t    op;
  } hpp_row_t;
  localparam int DONE_CYC = 80;    // array job outlasts a strobe
  localparam int LIMIT    = 80000; // hang ceiling in cycles
  logic        clk;
  logic        rstn;
  logic        hv_entry;
  logic        load_strobe;
  logic        page_latch_strobe;
  logic        wr_n;
  logic        oe_n;
  logic [1:0]  act;
  logic        byte_select_first;
  logic        byte_select_second;
  logic [7:0]  prog_data;
  logic [7:0]  data_in;
  logic [7:0]  data_out_q;
  logic        data_oe_q;
  logic        rb;
  logic        prog_mode_q;
  logic        pef;
  logic        nvm_start_q;
  hpp_op_t     nvm_op_q;
  logic [9:0]  nvm_page_q;
  logic [15:0] nvm_addr_q;
  logic [1:0]  nvm_sel_q;
  logic [7:0]  nvm_wdata_q;
  logic        nvm_buf_valid_q;
  logic        nvm_done;
  logic [15:0] nvm_rd_data;
  logic [5:0]  pb_rd_idx;
  logic [15:0] pb_rd_data;
  hpp_op_t     op_log[$];
  int          done_cnt;
  int          cyc;
  int          mismatches;
  int          check_count;
  int          n0;
  logic        ok;
  // fuse bytes indexed by {second,first}: low, lock, extended, high
  logic [7:0]  fexp [4] = '{8'h62, 8'h3c, 8'hf5, 8'hd9};
  hpp_row_t    rows [10] = '{
    '{`HPP_CMD_ERASE,    3, HPP_OP_ERASE_FLASH},
    '{`HPP_CMD_WR_FUSE,  1, HPP_OP_WR_FUSE},
    '{`HPP_CMD_WR_LOCK,  1, HPP_OP_WR_LOCK},
    '{`HPP_CMD_WR_FLASH, 1, HPP_OP_PROG_FLASH},
    '{`HPP_CMD_WR_EE,    1, HPP_OP_PROG_EE},
    '{`HPP_CMD_RD_SIG,   0, HPP_OP_NONE},
    '{`HPP_CMD_RD_FUSE,  0, HPP_OP_NONE},
    '{`HPP_CMD_RD_FLASH, 0, HPP_OP_NONE},
    '{`HPP_CMD_RD_EE,    0, HPP_OP_NONE},
    '{`HPP_CMD_NOP,      0, HPP_OP_NONE}};
  ////////////////////////////////////////////////////////////////////////
  // bus level: device, else programmer, else inverted stale value
  assign data_in = data_oe_q ? data_out_q : (oe_n ? prog_data : ~prog_data);
  // array read word derived from the address
  assign nvm_rd_data = {~nvm_addr_q[7:0], nvm_addr_q[7:0]};
  always #2.5 clk = ~clk;
  hpp_prog_port #(.PAGE_WORDS(64)) u_dut (
    .clk                  (clk),
    .rstn                 (rstn),
    .hv_entry             (hv_entry),
    .prog_mode_q          (prog_mode_q),
    .load_strobe          (load_strobe),
    .page_latch_strobe    (page_latch_strobe),
    .wr_n                 (wr_n),
    .oe_n                 (oe_n),
    .action_select_lo     (act[0]),
    .action_select_hi     (act[1]),
    .byte_select_first    (byte_select_first),
    .byte_select_second   (byte_select_second),
    .data_in              (data_in),
    .data_out_q           (data_out_q),
    .data_oe_q            (data_oe_q),
    .ready_busy_out       (rb),
    .preserve_eeprom_fuse (pef),
    .fuse_lo              (fexp[0]),
    .fuse_hi              (fexp[3]),
    .fuse_ext             (fexp[2]),
    .lock_bits            (fexp[1]),
    .nvm_start_q          (nvm_start_q),
    .nvm_op_q             (nvm_op_q),
    .nvm_page_q           (nvm_page_q),
    .nvm_addr_q           (nvm_addr_q),
    .nvm_sel_q            (nvm_sel_q),
    .nvm_wdata_q          (nvm_wdata_q),
    .nvm_buf_valid_q      (nvm_buf_valid_q),
    .nvm_done             (nvm_done),
    .nvm_rd_data          (nvm_rd_data),
    .pb_rd_idx            (pb_rd_idx),
    .pb_rd_data           (pb_rd_data)
  );
  hpp_prog_model u_prog (
    .clk               (clk),
    .hv_entry          (hv_entry),
    .load_strobe       (load_strobe),
    .page_latch_strobe (page_latch_strobe),
    .wr_n              (wr_n),
    .oe_n              (oe_n),
    .act               (act),
    .byte_select_first  (byte_select_first),
    .byte_select_second (byte_select_second),
    .prog_data         (prog_data),
    .ready_busy_out    (rb)
  );
  // array stand-in: logs each job, answers it after DONE_CYC edges
  always @(posedge clk)
  begin
    if (nvm_start_q === 1'b1)
    begin
      op_log.push_back(nvm_op_q);
      done_cnt <= DONE_CYC;
    end
    else if (done_cnt != 0)
      done_cnt <= done_cnt - 1;
    nvm_done <= (done_cnt == 1) && (nvm_start_q !== 1'b1);
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    pef = 1'b1;
    pb_rd_idx = 6'h00;
    nvm_done = 1'b0;
    done_cnt = 0;
    cyc = 0;
    mismatches = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk("mode", 16'h0, 16'(prog_mode_q));
    chk("ready", 16'h1, 16'(rb));
    chk("bus_oe", 16'h0, 16'(data_oe_q));
    u_prog.wr_pulse();
    chk("ready", 16'h1, 16'(rb));
    chk("jobs", 16'h0, 16'(op_log.size()));
    $display("test reset done");
    u_prog.enter(1'b1);
    chk("mode", 16'h0, 16'(prog_mode_q));
    u_prog.enter(1'b0);
    chk("mode", 16'h1, 16'(prog_mode_q));
    $display("test entry done");
    // every command byte through one write pulse
    foreach (rows[i])
    begin
      u_prog.load(2'h2, 1'b0, rows[i].cmd);
      n0 = op_log.size();
      u_prog.wr_pulse();
      chk("busy", 16'(rows[i].n_ops == 0), 16'(rb));
      u_prog.wait_ready(ok);
      chk("ready", 16'h1, 16'(ok));
      chk("jobs", 16'(rows[i].n_ops), 16'(op_log.size() - n0));
      if (rows[i].n_ops != 0)
        chk("job", 16'(rows[i].op), 16'(op_log[n0]));
    end
    $display("test commands done");
    // erase with preserve fuse programmed: flash, then locks only
    pef = 1'b0;
    u_prog.load(2'h2, 1'b0, `HPP_CMD_ERASE);
    n0 = op_log.size();
    u_prog.wr_pulse();
    u_prog.wait_ready(ok);
    chk("jobs", 16'h2, 16'(op_log.size() - n0));
    chk("last", 16'(HPP_OP_ERASE_LOCK), 16'(op_log[n0 + 1]));
    pef = 1'b1;
    $display("test erase done");
    // page write at word 5 of page 0x0d, then page 0x0e
    u_prog.load(2'h2, 1'b0, `HPP_CMD_WR_FLASH);
    u_prog.load(2'h0, 1'b0, 8'h45);
    u_prog.load(2'h1, 1'b0, 8'h34);
    u_prog.load(2'h1, 1'b1, 8'h12);
    u_prog.latch();
    pb_rd_idx = 6'h05;
    repeat (2) @(posedge clk);
    #1;
    chk("pbuf", 16'h1234, pb_rd_data);
    chk("valid", 16'h1, 16'(nvm_buf_valid_q));
    u_prog.load(2'h0, 1'b1, 8'h03);
    chk("addr", 16'h0345, nvm_addr_q);
    u_prog.wr_pulse();
    chk("busy", 16'h0, 16'(rb));
    chk("page", 16'h0345 >> 6, 16'(nvm_page_q));
    chk("wdata", 16'h34, 16'(nvm_wdata_q));
    chk("sel", 16'h1, 16'(nvm_sel_q));
    u_prog.wait_ready(ok);
    chk("valid", 16'h0, 16'(nvm_buf_valid_q));
    u_prog.load(2'h0, 1'b0, 8'h85);
    u_prog.latch();
    u_prog.wr_pulse();
    u_prog.wait_ready(ok);
    chk("job", 16'(HPP_OP_PROG_FLASH), 16'(op_log[$]));
    chk("page", 16'h0385 >> 6, 16'(nvm_page_q));
    u_prog.latch();
    u_prog.load(2'h2, 1'b0, `HPP_CMD_NOP);
    chk("valid", 16'h0, 16'(nvm_buf_valid_q));
    $display("test page done");
    // fuse and lock reads over all four select pairs
    u_prog.load(2'h2, 1'b0, `HPP_CMD_RD_FUSE);
    for (int i = 0; i < 4; i++)
    begin
      u_prog.pins(1'b0, i[1], i[0]);
      chk("bus_oe", 16'h1, 16'(data_oe_q));
      chk("fuse", 16'(fexp[i]), 16'(data_out_q));
    end
    u_prog.pins(1'b1, 1'b0, 1'b0);
    chk("bus_oe", 16'h0, 16'(data_oe_q));
    u_prog.load(2'h2, 1'b0, `HPP_CMD_RD_FLASH);
    u_prog.pins(1'b0, 1'b0, 1'b0);
    chk("rd_lo", 16'h85, 16'(data_out_q));
    u_prog.pins(1'b0, 1'b0, 1'b1);
    chk("rd_hi", 16'h7a, 16'(data_out_q));
    u_prog.pins(1'b1, 1'b0, 1'b0);
    // eeprom read gives the low byte whatever the first select says
    u_prog.load(2'h2, 1'b0, `HPP_CMD_RD_EE);
    u_prog.pins(1'b0, 1'b0, 1'b1);
    chk("rd_ee", 16'h85, 16'(data_out_q));
    u_prog.pins(1'b1, 1'b0, 1'b0);
    $display("test reads done");
    // leaving the mode silences the bus
    u_prog.leave();
    chk("mode", 16'h0, 16'(prog_mode_q));
    u_prog.pins(1'b0, 1'b0, 1'b0);
    chk("bus_oe", 16'h0, 16'(data_oe_q));
    u_prog.pins(1'b1, 1'b0, 1'b0);
    $display("test exit done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
